// File: gpp_port.sv
// top of the eight-pin general-purpose port
// assumes cpu strobes synchronous to clk and pins sampled synchronously
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_port (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// system state
	input wire gpp_pkg::gpp_mode_t mode,
	input wire gpp_pkg::gpp_pwr_t pwr,
	// register port
	input wire logic [15:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	// sources for pins
	input wire logic [7:0] addrOut,
	input wire logic [7:0] pwmOut,
	input wire logic [7:0] pwmEn,
	input wire logic [7:0] modOut,
	input wire logic [7:0] modEn,
	// pins
	input wire logic [7:0] pinIn,
	output logic [7:0] pinOut,
	output logic [7:0] pinOe,
	output logic [7:0] pullEn
);
	gpp_cfg_if cfg ();
	logic hwStandby;
	logic [7:0] pinOut_ff;
	logic [7:0] pinOe_ff;
	logic [7:0] pullEn_ff;
	logic [7:0] nxt_pinOut;
	logic [7:0] nxt_pinOe;
	logic [7:0] nxt_pullEn;
	logic nxt_addrSel;

	assign hwStandby = (pwr == gpp_pkg::GPP_HW_STBY);

	// ============================================================
	// registers
	gpp_regs gpp_regs_i (
		.clk(clk),
		.srst(srst),
		.hwStandby(hwStandby),
		.addr(addr),
		.wrData(wrData),
		.wrStb(wrStb),
		.rdStb(rdStb),
		.pinLevel(pinIn),
		.rdData(rdData),
		.cfg(cfg.regs)
	);

	// ============================================================
	// pin function
	gpp_pin_mux gpp_pin_mux_i (
		.mode(mode),
		.pwr(pwr),
		.addrOut(addrOut),
		.pwmOut(pwmOut),
		.pwmEn(pwmEn),
		.modOut(modOut),
		.modEn(modEn),
		.cfg(cfg.mux),
		.nxtPinOut(nxt_pinOut),
		.nxtPinOe(nxt_pinOe),
		.nxtPullEn(nxt_pullEn),
		.nxtAddrSel(nxt_addrSel)
	);

	// ============================================================
	// pin flops; in software standby the last driven levels are frozen
	always_ff @(posedge clk) begin
		if (srst) begin
			pinOut_ff <= 8'h00;
			pinOe_ff <= 8'h00;
			pullEn_ff <= 8'h00;
		end else if (pwr == gpp_pkg::GPP_SW_STBY) begin
			pinOut_ff <= pinOut_ff;
			pinOe_ff <= pinOe_ff;
			pullEn_ff <= pullEn_ff;
		end else begin
			pinOut_ff <= nxt_pinOut;
			pinOe_ff <= nxt_pinOe;
			pullEn_ff <= nxt_pullEn;
		end
	end

	assign pinOut = pinOut_ff;
	assign pinOe = pinOe_ff;
	assign pullEn = pullEn_ff;

	// ============================================================
	// checks
	mode1_drive_a: assert property (@(posedge clk) disable iff (srst)
		mode == gpp_pkg::GPP_MODE_1 && pwr == gpp_pkg::GPP_RUN
		|=> pinOe == 8'hFF && pinOut == $past(addrOut))
		else $error("mode one not driving address");
	addr_sel_a: assert property (@(posedge clk) disable iff (srst)
		mode == gpp_pkg::GPP_MODE_1 |-> nxt_addrSel)
		else $error("mode one not selecting address");
	mode1_float_a: assert property (@(posedge clk) disable iff (srst)
		mode == gpp_pkg::GPP_MODE_1 && hwStandby |=> pinOe == 8'h00)
		else $error("address pins not floated");
	sw_hold_a: assert property (@(posedge clk) disable iff (srst)
		pwr == gpp_pkg::GPP_SW_STBY |=> $stable(pinOut) && $stable(pinOe))
		else $error("pins moved in software standby");
	input_dir_a: assert property (@(posedge clk) disable iff (srst)
		mode == gpp_pkg::GPP_MODE_2 && pwr == gpp_pkg::GPP_RUN && cfg.dirBits[0] == 1'b0
		|=> pinOe[0] == 1'b0)
		else $error("input pin driven");
	gen_out_a: assert property (@(posedge clk) disable iff (srst)
		mode == gpp_pkg::GPP_MODE_3 && pwr == gpp_pkg::GPP_RUN && !cfg.expansionEnable
		&& cfg.dirBits[1] && !pwmEn[1] |=> pinOe[1] && pinOut[1] == $past(cfg.dataBits[1]))
		else $error("general output wrong");
	upper_pins_io_select_upper_a: assert property (@(posedge clk) disable iff (srst)
		mode == gpp_pkg::GPP_MODE_2 && pwr == gpp_pkg::GPP_RUN && cfg.expansionEnable
		&& cfg.upperPinsIoSelect && cfg.dirBits[5] && !pwmEn[5] && !modEn[5]
		|=> pinOut[5] == $past(cfg.dataBits[5]))
		else $error("upper pin not general output");
	pull_input_a: assert property (@(posedge clk) disable iff (srst)
		pullEn != 8'h00 |-> (pullEn & pinOe) == 8'h00)
		else $error("pull-up on driven pin");
	mod_out_a: assert property (@(posedge clk) disable iff (srst)
		mode == gpp_pkg::GPP_MODE_2 && pwr == gpp_pkg::GPP_RUN && modEn[7]
		|=> pinOe[7] && pinOut[7] == $past(modOut[7]))
		else $error("module output not routed");
endmodule : gpp_port

// File: gpp_params.svh
// constants for the eight-pin general-purpose port: offsets, reset values, field positions
// assumes it is included by bare name from the port and register design files
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH

// ============================================================
// register offsets (low sixteen address bits)
`define GPP_ADDR_W 16
`define GPP_OFS_PULLUP 16'hFFAD
`define GPP_OFS_DIR 16'hFFB1
`define GPP_OFS_DATA 16'hFFB3
`define GPP_OFS_CTRL 16'hFFB5

// ============================================================
// reset values and widths
`define GPP_PINS 8
`define GPP_RST_PULLUP 8'h00
`define GPP_RST_DIR 8'h00
`define GPP_RST_DATA 8'h00
`define GPP_RST_CTRL 8'h00
`define GPP_UNDEF_READ 8'h00

// ============================================================
// control register fields
`define GPP_CTRL_EXP_BIT 0
`define GPP_CTRL_UPPER_PINS_IO_SELECT_BIT 1
`define GPP_UPPER_LO 4
`define GPP_MODULE_LO 3
`define GPP_TOP_PIN 7

`endif

// File: gpp_pkg.sv
// types shared by the port modules
// assumes the params header sits in the same folder
package gpp_pkg;
	typedef enum logic [1:0] {
		GPP_MODE_RSVD = 2'b00,
		GPP_MODE_1 = 2'b01,
		GPP_MODE_2 = 2'b10,
		GPP_MODE_3 = 2'b11
	} gpp_mode_t;

	typedef enum logic [1:0] {
		GPP_RUN = 2'b00,
		GPP_SW_STBY = 2'b01,
		GPP_HW_STBY = 2'b10
	} gpp_pwr_t;
endpackage : gpp_pkg

// File: gpp_cfg_if.sv
// carries the register state from the register file to the pin mux
// assumes a single clock domain
`timescale 1ns/1ps
interface gpp_cfg_if;
	logic [7:0] dirBits;
	logic [7:0] dataBits;
	logic [7:0] pullBits;
	logic expansionEnable;
	logic upperPinsIoSelect;
	modport regs (output dirBits, output dataBits, output pullBits,
		output expansionEnable, output upperPinsIoSelect);
	modport mux (input dirBits, input dataBits, input pullBits,
		input expansionEnable, input upperPinsIoSelect);
endinterface : gpp_cfg_if

// File: gpp_regs.sv
// register file of the port: pull-up, direction, data and control
// assumes one-cycle strobes from the cpu side, synchronous reset
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_regs (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	input wire logic hwStandby,
	// cpu side
	input wire logic [15:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	input wire logic [7:0] pinLevel,
	output logic [7:0] rdData,
	// configuration out
	gpp_cfg_if.regs cfg
);
	logic [7:0] dir_ff;
	logic [7:0] data_ff;
	logic [7:0] pull_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] rd_ff;
	logic [7:0] nxt_rd;

	// ============================================================
	// decode
	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// ============================================================
	// direction: cleared by reset and hardware standby, kept in software standby
	always_ff @(posedge clk) begin
		if (srst || hwStandby) begin
			dir_ff <= `GPP_RST_DIR;
		end else if (wrStb && hit(addr, `GPP_OFS_DIR)) begin
			dir_ff <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || hwStandby) begin
			data_ff <= `GPP_RST_DATA;
		end else if (wrStb && hit(addr, `GPP_OFS_DATA)) begin
			data_ff <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || hwStandby) begin
			pull_ff <= `GPP_RST_PULLUP;
		end else if (wrStb && hit(addr, `GPP_OFS_PULLUP)) begin
			pull_ff <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || hwStandby) begin
			ctrl_ff <= `GPP_RST_CTRL;
		end else if (wrStb && hit(addr, `GPP_OFS_CTRL)) begin
			ctrl_ff <= {6'h00, wrData[1:0]};
		end
	end

	// ============================================================
	// read path; direction reads a fixed value since the bits are write-only
	always_comb begin
		nxt_rd = 8'h00;
		if (hit(addr, `GPP_OFS_DIR)) begin
			nxt_rd = `GPP_UNDEF_READ;
		end else if (hit(addr, `GPP_OFS_DATA)) begin
			nxt_rd = (data_ff & dir_ff) | (pinLevel & ~dir_ff);
		end else if (hit(addr, `GPP_OFS_PULLUP)) begin
			nxt_rd = pull_ff;
		end else if (hit(addr, `GPP_OFS_CTRL)) begin
			nxt_rd = ctrl_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_ff <= 8'h00;
		end else if (rdStb) begin
			rd_ff <= nxt_rd;
		end else begin
			rd_ff <= 8'h00;
		end
	end

	assign rdData = rd_ff;
	assign cfg.dirBits = dir_ff;
	assign cfg.dataBits = data_ff;
	assign cfg.pullBits = pull_ff;
	assign cfg.expansionEnable = ctrl_ff[`GPP_CTRL_EXP_BIT];
	assign cfg.upperPinsIoSelect = ctrl_ff[`GPP_CTRL_UPPER_PINS_IO_SELECT_BIT];

	// ============================================================
	// checks
	dir_hw_clear_a: assert property (@(posedge clk) disable iff (srst)
		hwStandby |=> dir_ff == 8'h00)
		else $error("direction not cleared in hardware standby");
	dir_write_a: assert property (@(posedge clk) disable iff (srst)
		wrStb && addr == 16'hFFB1 && !hwStandby |=> dir_ff == $past(wrData))
		else $error("direction write lost");
	pull_write_a: assert property (@(posedge clk) disable iff (srst)
		wrStb && addr == 16'hFFAD && !hwStandby |=> pull_ff == $past(wrData))
		else $error("pull-up write lost");
	dir_read_a: assert property (@(posedge clk) disable iff (srst)
		rdStb && addr == 16'hFFB1 |=> rdData == 8'h00)
		else $error("direction read leaks state");
	addr_match_a: assert property (@(posedge clk) disable iff (srst)
		wrStb && addr[7:0] == 8'hB1 && addr[15:8] != 8'hFF && !srst && !hwStandby
		|=> $stable(dir_ff))
		else $error("decoder ignored upper address bits");
endmodule : gpp_regs

// File: gpp_pin_mux.sv
// per-pin function select: address, pwm, module output, general output or input
// assumes mode and standby states are steady levels from the system controller
`timescale 1ns/1ps
module gpp_pin_mux (
	// state
	input wire gpp_pkg::gpp_mode_t mode,
	input wire gpp_pkg::gpp_pwr_t pwr,
	// sources
	input wire logic [7:0] addrOut,
	input wire logic [7:0] pwmOut,
	input wire logic [7:0] pwmEn,
	input wire logic [7:0] modOut,
	input wire logic [7:0] modEn,
	gpp_cfg_if.mux cfg,
	// pin drive
	output logic [7:0] nxtPinOut,
	output logic [7:0] nxtPinOe,
	output logic [7:0] nxtPullEn,
	output logic nxtAddrSel
);
	integer i;
	always_comb begin
		nxtPinOut = 8'h00;
		nxtPinOe = 8'h00;
		nxtPullEn = 8'h00;
		nxtAddrSel = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			case (mode)
				gpp_pkg::GPP_MODE_1: begin
					nxtAddrSel = 1'b1;
					nxtPinOut[i] = addrOut[i];
					nxtPinOe[i] = (pwr != gpp_pkg::GPP_HW_STBY);
				end
				gpp_pkg::GPP_MODE_2, gpp_pkg::GPP_MODE_3: begin
					if (cfg.dirBits[i]) begin
						nxtPinOe[i] = 1'b1;
						if (pwmEn[i]) begin
							nxtPinOut[i] = pwmOut[i];
						end else if (cfg.expansionEnable && !(cfg.upperPinsIoSelect && i >= 4)) begin
							nxtAddrSel = 1'b1;
							nxtPinOut[i] = addrOut[i];
						end else begin
							nxtPinOut[i] = cfg.dataBits[i];
						end
					end
					// module outputs on the upper five pins override the direction bit
					if (i >= 3 && modEn[i]) begin
						nxtPinOe[i] = 1'b1;
						nxtPinOut[i] = modOut[i];
					end
					if (pwr == gpp_pkg::GPP_HW_STBY) begin
						nxtPinOe[i] = 1'b0;
					end
					nxtPullEn[i] = cfg.pullBits[i] && !nxtPinOe[i];
				end
				default: begin
					nxtPinOe[i] = 1'b0;
				end
			endcase
		end
	end
endmodule : gpp_pin_mux

// File: gpp_board_model.sv
// board-side model of the eight port pins
// assumes the port samples pinIn on clk
`timescale 1ns/1ps
module gpp_board_model (
	// clock
	input wire logic clk,
	// port drive
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic [7:0] pullEn,
	// board drive
	input wire logic [7:0] extVal,
	input wire logic [7:0] extEn,
	// level seen by the port
	output logic [7:0] pinIn
);
	// ============================================================
	// pin resolution
	// a floating pin flips every cycle so it never passes for a steady level
	logic [7:0] floatPat_ff = 8'h5A;
	always_ff @(posedge clk) begin
		floatPat_ff <= ~floatPat_ff;
	end
	always_comb begin
		pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal)
			| (~pinOe & ~extEn & (pullEn | floatPat_ff));
	end
endmodule : gpp_board_model

// File: tb.sv
// self-checking bench for the eight-pin port
// assumes the design files and the board model are compiled first
`timescale 1ns/1ps
module tb;
	// ============================================================
	// stimulus and hookup
	logic clk = 1'b0;
	logic srst = 1'b1;
	gpp_pkg::gpp_mode_t mode = gpp_pkg::GPP_MODE_2;
	gpp_pkg::gpp_pwr_t pwr = gpp_pkg::GPP_RUN;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wrData = 8'h00, addrOut = 8'h00, pwmOut = 8'h00, pwmEn = 8'h00;
	logic [7:0] modOut = 8'h00, modEn = 8'h00, extVal = 8'hC3;
	logic [7:0] extEn = 8'hFF;
	logic wrStb = 1'b0;
	logic rdStb = 1'b0;
	logic [7:0] rdData, pinIn, pinOut, pinOe, pullEn;
	logic [7:0] dir = 8'h00, dat = 8'h00, pul = 8'h00, ctl = 8'h00;
	logic [23:0] e;
	int nErrors = 0;
	int samplesChecked = 0;
	int seed = 40506;

	initial forever #2 clk = ~clk;

	gpp_port gpp_port_i (.clk(clk), .srst(srst), .mode(mode), .pwr(pwr), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .addrOut(addrOut),
		.pwmOut(pwmOut), .pwmEn(pwmEn), .modOut(modOut), .modEn(modEn), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn));
	gpp_board_model gpp_board_model_i (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
		.pullEn(pullEn), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

	// ============================================================
	// checks and bus cycles
	task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
		samplesChecked++;
		if (g !== x) begin
			nErrors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] x, input string nm);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1 chk(nm, x, rdData);
	endtask : rd

	// expected {pinOut & pinOe, pinOe, pullEn}
	function automatic logic [23:0] expPins();
		logic [7:0] oe, o, pu;
		logic me;
		oe = 8'h00;
		o = 8'h00;
		pu = 8'h00;
		if (pwr == gpp_pkg::GPP_HW_STBY) return 24'h00_0000;
		if (mode == gpp_pkg::GPP_MODE_1) begin
			oe = 8'hFF;
			o = addrOut;
		end else if (mode != gpp_pkg::GPP_MODE_RSVD) begin
			for (int i = 0; i < 8; i++) begin
				me = (i >= 3) && modEn[i];
				oe[i] = dir[i] | me;
				o[i] = me ? modOut[i] : pwmEn[i] ? pwmOut[i]
					: (ctl[0] && !(ctl[1] && i >= 4)) ? addrOut[i] : dat[i];
				pu[i] = pul[i] & ~oe[i];
			end
		end
		return {o & oe, oe, pu};
	endfunction : expPins

	task automatic chkPins(input logic [23:0] x);
		chk("pinOut", x[23:16], pinOut & pinOe);
		chk("pinOe", x[15:8], pinOe);
		chk("pullEn", x[7:0], pullEn);
	endtask : chkPins

	task automatic randSrc();
		logic [7:0] r;
		r = $random(seed);
		addrOut <= $random(seed);
		pwmOut <= $random(seed);
		pwmEn <= $random(seed) & ~r;
		modOut <= $random(seed);
		modEn <= r & 8'hF8;
	endtask : randSrc

	task automatic finalReport();
		$display("errors %0d checks %0d", nErrors, samplesChecked);
		if (nErrors == 0 && samplesChecked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finalReport

	// ============================================================
	// main sequence
	initial begin
		int k;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(16'hFFAD, 8'h00, "pullupReset");
		rd(16'hFFB5, 8'h00, "ctrlReset");
		rd(16'hFFB3, 8'hC3, "dataReset");
		chkPins(24'h00_0000);
		repeat (40) begin
			k = $unsigned($random(seed)) % 4;
			mode <= gpp_pkg::gpp_mode_t'(k[1:0]);
			extVal <= $random(seed);
			randSrc();
			dir = $random(seed);
			dat = $random(seed);
			pul = $random(seed);
			ctl = $random(seed);
			wr(16'hFFAD, pul);
			wr(16'hFFB1, dir);
			wr(16'hFFB3, dat);
			wr(16'hFFB5, ctl);
			ctl = ctl & 8'h03;
			repeat (2) @(posedge clk);
			#1 e = expPins();
			chkPins(e);
			wr(16'h7FB3, ~dat);
			wr(16'h7FB1, ~dir);
			rd(16'h7FB3, 8'h00, "unmapped");
			rd(16'hFFB3, (dat & dir) | (e[23:16] & dir) ^ (e[23:16] & dir)
				| ((e[23:16] & e[15:8] | extVal & ~e[15:8]) & ~dir), "data");
			rd(16'hFFB1, 8'h00, "dirRead");
			rd(16'hFFAD, pul, "pullup");
			rd(16'hFFB5, ctl, "ctrl");
		end
		// outputs freeze while sources move under software standby
		e = expPins();
		@(posedge clk);
		pwr <= gpp_pkg::GPP_SW_STBY;
		randSrc();
		repeat (3) @(posedge clk);
		#1 chkPins(e);
		pwr <= gpp_pkg::GPP_RUN;
		repeat (2) @(posedge clk);
		#1 chkPins(expPins());
		mode <= gpp_pkg::GPP_MODE_1;
		pwr <= gpp_pkg::GPP_HW_STBY;
		wr(16'hFFAD, 8'hFF);
		repeat (2) @(posedge clk);
		#1 chk("hwStbyOe", 8'h00, pinOe);
		pwr <= gpp_pkg::GPP_RUN;
		mode <= gpp_pkg::GPP_MODE_2;
		modEn <= 8'h00;
		dir = 8'h00;
		pul = 8'h00;
		repeat (2) @(posedge clk);
		#1 chkPins(expPins());
		rd(16'hFFAD, 8'h00, "pullupHw");
		// undriven input pins with pull-ups on read high
		extEn <= 8'h00;
		pul = 8'hFF;
		wr(16'hFFAD, pul);
		repeat (2) @(posedge clk);
		#1 chkPins(expPins());
		rd(16'hFFB3, 8'hFF, "pulledIn");
		finalReport();
	end

	// the whole sequence needs about a thousand cycles; this is far beyond that
	initial begin
		#100000;
		nErrors++;
		finalReport();
	end
endmodule : tb
